/* File: src/mvc_capture_writer.sv */
// Purpose: capture the live pixel stream and write it, optionally masked, into the frame buffer
// Assumes: capture pins are asynchronous to clk and much slower; frame buffer port on clk
// Notes: pixels that arrive while the two-entry buffer is full are dropped and flagged
`timescale 1ns/1ps

module mvc_capture_writer
	import mvc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic capture_clock,
	input wire logic frame_start_n,
	input wire logic line_end_n,
	input wire logic capture_word_valid,
	input wire logic field_parity,
	input wire logic [PIX_W-1:0] capture_pixel_bus,
	output logic fb_valid,
	output logic fb_write,
	output logic [ADDR_W-1:0] fb_addr,
	output logic [PIX_W-1:0] fb_wdata,
	input wire logic fb_ready,
	input wire logic fb_rdata_valid,
	input wire logic [7:0] fb_rdata
);

	// byte address of the mask byte that covers a pixel at byte address a
	function automatic logic [ADDR_W-1:0] mask_byte_addr(input logic [ADDR_W-1:0] base,
			input logic [ADDR_W-1:0] a);
		mask_byte_addr = base + (a >> (PIX_SHIFT + BYTE_SHIFT));
	endfunction

	// bit position in that byte; the leftmost pixel sits in the msb
	function automatic logic [2:0] mask_bit_pos(input logic [ADDR_W-1:0] a);
		mask_bit_pos = MSB_POS - a[PIX_SHIFT +: BYTE_SHIFT];
	endfunction

	mvc_pins_t pins_raw, sync1, sync2;
	logic clk_prev, rise;
	// two-flop synchronisers; sync1 is read by sync2 only
	assign pins_raw = '{capture_clock, frame_start_n, line_end_n, capture_word_valid,
		field_parity, capture_pixel_bus};
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
			clk_prev <= 1'b0;
		end else if (ce) begin
			sync1 <= pins_raw;
			sync2 <= sync1;
			clk_prev <= sync2.clk_lvl;
		end
	end
	// bus and controls are taken at the rising edge of the capture clock
	assign rise = sync2.clk_lvl & ~clk_prev;

	// registers
	logic [7:0] ctrl, next_ctrl, rdata_q, next_rdata;
	logic [ADDR_W-1:0] mask_base, next_mask_base, cap_base, next_cap_base;
	logic [7:0] line_ofs, next_line_ofs;
	logic ovr, next_ovr, ovr_set;
	logic [1:0] fcount;
	// register writes and reads; the overflow flag's set wins over its clear
	always_comb begin
		next_ctrl = ctrl;
		next_mask_base = mask_base;
		next_cap_base = cap_base;
		next_line_ofs = line_ofs;
		next_ovr = ovr;
		next_rdata = rdata_q;
		if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: begin
					next_ctrl = reg_wdata;
					next_ctrl[CTRL_CLR_OVR] = 1'b0;
					if (reg_wdata[CTRL_CLR_OVR])
						next_ovr = 1'b0;
				end
				OFS_MASK_B0: next_mask_base[7:0] = reg_wdata;
				OFS_MASK_B1: next_mask_base[15:8] = reg_wdata;
				OFS_MASK_B2: next_mask_base[23:16] = reg_wdata;
				OFS_CAP_B0: next_cap_base[7:0] = reg_wdata;
				OFS_CAP_B1: next_cap_base[15:8] = reg_wdata;
				OFS_CAP_B2: next_cap_base[23:16] = reg_wdata;
				OFS_LINE: next_line_ofs = reg_wdata;
				default: ;
			endcase
		end
		if (ovr_set)
			next_ovr = 1'b1;
		if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL: next_rdata = ctrl;
				OFS_STATUS: begin
					next_rdata = RST_BYTE;
					next_rdata[STAT_OVR] = ovr;
					next_rdata[STAT_FIELD] = sync2.field;
					next_rdata[STAT_BUSY] = (fcount != 2'h0);
				end
				OFS_MASK_B0: next_rdata = mask_base[7:0];
				OFS_MASK_B1: next_rdata = mask_base[15:8];
				OFS_MASK_B2: next_rdata = mask_base[23:16];
				OFS_CAP_B0: next_rdata = cap_base[7:0];
				OFS_CAP_B1: next_rdata = cap_base[15:8];
				OFS_CAP_B2: next_rdata = cap_base[23:16];
				OFS_LINE: next_rdata = line_ofs;
				default: next_rdata = RST_BYTE; // unmapped reads as zero
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= RST_BYTE;
			mask_base <= RST_ADDR;
			cap_base <= RST_ADDR;
			line_ofs <= RST_BYTE;
			ovr <= 1'b0;
			rdata_q <= RST_BYTE;
		end else if (ce) begin
			ctrl <= next_ctrl;
			mask_base <= next_mask_base;
			cap_base <= next_cap_base;
			line_ofs <= next_line_ofs;
			ovr <= next_ovr;
			rdata_q <= next_rdata;
		end
	end
	assign reg_rdata = rdata_q;

	// capture address counter; frame start beats line end beats data
	logic [ADDR_W-1:0] cap_addr, next_cap_addr, line_start, next_line_start;
	logic push, pop, full;
	logic take_frame, take_line, take_word;
	assign take_frame = rise & ~sync2.frame_start_n;
	assign take_line = rise & sync2.frame_start_n & ~sync2.line_end_n;
	assign take_word = rise & sync2.frame_start_n & sync2.line_end_n & sync2.word_valid;
	assign push = take_word & ~full;
	assign ovr_set = take_word & full; // the source cannot be stalled, so flag the loss
	always_comb begin
		next_cap_addr = cap_addr;
		next_line_start = line_start;
		if (take_frame) begin
			next_cap_addr = cap_base;
			next_line_start = cap_base;
		end else if (take_line) begin
			next_line_start = line_start + {16'h0000, line_ofs};
			next_cap_addr = line_start + {16'h0000, line_ofs};
		end else if (push) begin
			next_cap_addr = cap_addr + PIX_BYTES;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			cap_addr <= RST_ADDR;
			line_start <= RST_ADDR;
		end else if (ce) begin
			cap_addr <= next_cap_addr;
			line_start <= next_line_start;
		end
	end

	// two-entry buffer between capture and frame-buffer writer
	mvc_word_t fifo_mem [FIFO_DEPTH];
	logic wptr, rptr, next_wptr, next_rptr;
	logic [1:0] next_fcount;
	mvc_word_t head;
	assign full = (fcount == 2'(FIFO_DEPTH));
	assign head = fifo_mem[rptr];
	always_comb begin
		next_wptr = wptr ^ push;
		next_rptr = rptr ^ pop;
		next_fcount = fcount + {1'b0, push} - {1'b0, pop};
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wptr <= 1'b0;
			rptr <= 1'b0;
			fcount <= 2'h0;
		end else if (ce) begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			fcount <= next_fcount;
		end
	end

	// storage needs no reset; only entries counted in fcount are read
	always_ff @(posedge clk) begin
		if (ce && push)
			fifo_mem[wptr] <= '{cap_addr, sync2.pixel};
	end

	// frame-buffer writer: optional byte-wide mask fetch, then the pixel write unless its mask bit is clear
	mvc_state_t state, next_state;
	logic next_fb_write;
	logic [ADDR_W-1:0] next_fb_addr;
	logic [PIX_W-1:0] next_fb_wdata;
	logic mask_on;
	assign mask_on = ctrl[CTRL_MASK_EN];
	always_comb begin
		next_state = state;
		next_fb_write = fb_write;
		next_fb_addr = fb_addr;
		next_fb_wdata = fb_wdata;
		pop = 1'b0;
		case (state)
			ST_IDLE: begin
				if (fcount != 2'h0) begin
					if (mask_on) begin
						next_state = ST_MREQ;
						next_fb_write = 1'b0;
						next_fb_addr = mask_byte_addr(mask_base, head.addr);
					end else begin
						next_state = ST_WREQ;
						next_fb_write = 1'b1;
						next_fb_addr = head.addr;
						next_fb_wdata = head.pixel;
					end
				end
			end
			ST_MREQ: if (fb_ready) next_state = ST_MWAIT;
			ST_MWAIT: begin
				if (fb_rdata_valid) begin
					if (fb_rdata[mask_bit_pos(head.addr)]) begin
						next_state = ST_WREQ;
						next_fb_write = 1'b1;
						next_fb_addr = head.addr;
						next_fb_wdata = head.pixel;
					end else begin
						next_state = ST_IDLE;
						pop = 1'b1;
					end
				end
			end
			ST_WREQ: begin
				if (fb_ready) begin
					next_state = ST_IDLE;
					pop = 1'b1;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			fb_write <= 1'b0;
			fb_addr <= RST_ADDR;
			fb_wdata <= '0;
		end else if (ce) begin
			state <= next_state;
			fb_write <= next_fb_write;
			fb_addr <= next_fb_addr;
			fb_wdata <= next_fb_wdata;
		end
	end
	assign fb_valid = (state == ST_MREQ) || (state == ST_WREQ);

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_fifo_bound;
		fcount <= 2'(FIFO_DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("buffer count over depth");
	property p_frame_load;
		ce && take_frame |=> cap_addr == $past(cap_base) && line_start == cap_addr;
	endproperty
	a_frame_load: assert property (p_frame_load) else $error("frame start load wrong");
	property p_line_load;
		ce && take_line |=> cap_addr == $past(line_start) + {16'h0000, $past(line_ofs)};
	endproperty
	a_line_load: assert property (p_line_load) else $error("line end reload wrong");
	property p_word_step;
		ce && push |=> cap_addr == $past(cap_addr) + PIX_BYTES && fcount == $past(fcount) + 2'h1
			- {1'b0, $past(pop)};
	endproperty
	a_word_step: assert property (p_word_step) else $error("valid word not taken");
	property p_mask_drop;
		ce && state == ST_MWAIT && fb_rdata_valid && !fb_rdata[mask_bit_pos(head.addr)]
			|=> state == ST_IDLE && !fb_valid;
	endproperty
	a_mask_drop: assert property (p_mask_drop) else $error("masked pixel not dropped");
	property p_unmasked_write;
		ce && state == ST_IDLE && fcount != 2'h0 && !mask_on
			|=> state == ST_WREQ && fb_write && fb_addr == $past(head.addr);
	endproperty
	a_unmasked_write: assert property (p_unmasked_write) else $error("unmasked write missing");
	property p_mask_addr;
		fb_valid && !fb_write |-> fb_addr == mask_byte_addr(mask_base, head.addr);
	endproperty
	a_mask_addr: assert property (p_mask_addr) else $error("mask byte address wrong");
	property p_write_data;
		fb_valid && fb_write |-> fb_wdata == head.pixel && fb_addr == head.addr;
	endproperty
	a_write_data: assert property (p_write_data) else $error("pixel word altered");
	property p_mask_gates;
		ce && state == ST_IDLE && fcount != 2'h0 && mask_on |=> state == ST_MREQ && !fb_write;
	endproperty
	a_mask_gates: assert property (p_mask_gates) else $error("mask not fetched first");
	property p_ovr_sticky;
		ce && ovr_set |=> ovr;
	endproperty
	a_ovr_sticky: assert property (p_ovr_sticky) else $error("overflow flag lost");
	c_masked_drop: cover property (state == ST_MWAIT ##1 state == ST_IDLE && !fb_valid);
	c_masked_write: cover property (state == ST_MWAIT ##1 state == ST_WREQ);
	c_overflow: cover property (ovr_set);
	c_line_then_word: cover property (take_line ##[1:40] push);
endmodule // mvc_capture_writer

/* File: src/mvc_pkg.sv */
// Purpose: shared constants and types for the masked video capture writer
// Assumes: byte-wide register port, 24-bit frame-buffer byte addresses
// Notes: one 16-bit pixel word per capture cycle, two bytes of frame buffer each
package mvc_pkg;

	localparam int ADDR_W = 24;
	localparam int PIX_W = 16;
	localparam int FIFO_DEPTH = 2;

	// register offsets on the byte register port
	localparam logic [7:0] OFS_CTRL = 8'h96;
	localparam logic [7:0] OFS_STATUS = 8'h97;
	localparam logic [7:0] OFS_MASK_B0 = 8'h98;
	localparam logic [7:0] OFS_MASK_B1 = 8'h99;
	localparam logic [7:0] OFS_MASK_B2 = 8'h9a;
	localparam logic [7:0] OFS_CAP_B0 = 8'h9c;
	localparam logic [7:0] OFS_CAP_B1 = 8'h9d;
	localparam logic [7:0] OFS_CAP_B2 = 8'h9e;
	localparam logic [7:0] OFS_LINE = 8'h9f;

	// field positions
	localparam int CTRL_MASK_EN = 0;
	localparam int CTRL_CLR_OVR = 1;
	localparam int STAT_OVR = 0;
	localparam int STAT_FIELD = 1;
	localparam int STAT_BUSY = 2;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [ADDR_W-1:0] RST_ADDR = 24'h000000;

	// address stepping and mask indexing
	localparam logic [ADDR_W-1:0] PIX_BYTES = 24'h000002;
	localparam int PIX_SHIFT = 1;
	localparam int BYTE_SHIFT = 3;
	localparam logic [2:0] MSB_POS = 3'h7;

	// pins as sampled by the block clock
	typedef struct packed {
		logic clk_lvl;
		logic frame_start_n;
		logic line_end_n;
		logic word_valid;
		logic field;
		logic [PIX_W-1:0] pixel;
	} mvc_pins_t;

	// one captured word waiting for the frame buffer
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [PIX_W-1:0] pixel;
	} mvc_word_t;

	typedef enum logic [1:0] {ST_IDLE, ST_MREQ, ST_MWAIT, ST_WREQ} mvc_state_t;

endpackage

/* File: testbench/mvc_video_source.sv */
// Purpose: behavioural video source feeding the capture port
// Assumes: capture clock of 200 ns that stands low outside frames
// Notes: an idle pixel bus shows the inverse of its last value, never a held word
`timescale 1ns/1ps
module mvc_video_source
	import mvc_pkg::*;
(
	output logic capture_clock,
	output logic frame_start_n,
	output logic line_end_n,
	output logic capture_word_valid,
	output logic field_parity,
	output logic [PIX_W-1:0] capture_pixel_bus
);
	initial begin
		capture_clock = 1'b0;
		frame_start_n = 1'b1;
		line_end_n = 1'b1;
		capture_word_valid = 1'b0;
		field_parity = 1'b0;
		capture_pixel_bus = 16'h0000;
	end
	// one clock period, no time at all for idle; kind 0 frame start, 1 line end, 2 pixel, 3 idle
	task automatic cycle(input int kind, input logic [PIX_W-1:0] pix);
		frame_start_n = (kind != 0);
		line_end_n = (kind != 1);
		capture_word_valid = (kind == 2);
		capture_pixel_bus = (kind == 2) ? pix : ~capture_pixel_bus;
		// an idle cycle leaves the link clock standing low
		if (kind != 3) begin
			#100 capture_clock = 1'b1;
			#100 capture_clock = 1'b0;
		end
	endtask
endmodule // mvc_video_source

/* File: testbench/test_masked_video_capture_writer.sv */
// Purpose: self-checking bench for the masked capture writer
// Assumes: bench acts as frame-buffer memory, mask bytes derived from a random key
// Notes: expected writes are queued as pixels are sent
`timescale 1ns/1ps
module test_masked_video_capture_writer;
	import mvc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, fb_rdata = 8'h00, ofs, mkey, v;
	logic capture_clock, frame_start_n, line_end_n, capture_word_valid, field_parity;
	logic [PIX_W-1:0] capture_pixel_bus, fb_wdata;
	logic fb_valid, fb_write, fb_ready = 1'b0, fb_rdata_valid = 1'b0;
	logic [ADDR_W-1:0] fb_addr, mbase, cbase, line, cur, pa;
	logic men = 1'b0, stall = 1'b0, chk = 1'b1, pend = 1'b0;
	logic [31:0] tmp;
	int n_fail = 0, samples_checked = 0, cycles = 0, n_mw = 0;
	mvc_word_t q[$], cw;

	always #12.5 clk = ~clk;

	mvc_capture_writer i_mvc_capture_writer (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.capture_clock(capture_clock), .frame_start_n(frame_start_n), .line_end_n(line_end_n),
		.capture_word_valid(capture_word_valid), .field_parity(field_parity),
		.capture_pixel_bus(capture_pixel_bus), .fb_valid(fb_valid), .fb_write(fb_write),
		.fb_addr(fb_addr), .fb_wdata(fb_wdata), .fb_ready(fb_ready),
		.fb_rdata_valid(fb_rdata_valid), .fb_rdata(fb_rdata));

	mvc_video_source i_mvc_video_source (.capture_clock(capture_clock),
		.frame_start_n(frame_start_n), .line_end_n(line_end_n),
		.capture_word_valid(capture_word_valid), .field_parity(field_parity),
		.capture_pixel_bus(capture_pixel_bus));

	// mask memory content; any byte pattern is legal for the mask
	function automatic logic [7:0] mem_byte(input logic [ADDR_W-1:0] a);
		return a[7:0] ^ mkey;
	endfunction
	// pixel index is byte address over two, leftmost pixel in the msb
	function automatic logic mbit(input logic [ADDR_W-1:0] a);
		logic [7:0] b;
		b = mem_byte(mbase + (a >> 4));
		return b[3'h7 - a[3:1]];
	endfunction

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		v = reg_rdata;
	endtask

	task automatic pix(input logic [PIX_W-1:0] p);
		cw.addr = cur;
		cw.pixel = p;
		if (chk)
			q.push_back(cw);
		cur = cur + PIX_BYTES;
		i_mvc_video_source.cycle(2, p);
	endtask

	// one frame of lines, each line ended by a line end pulse
	task automatic frame(input int lines, input int n);
		line = cbase;
		cur = cbase;
		i_mvc_video_source.cycle(0, 16'h0000);
		for (int l = 0; l < lines; l++) begin
			for (int k = 0; k < n; k++)
				pix(16'($urandom));
			line = line + {16'h0000, ofs};
			cur = line;
			i_mvc_video_source.cycle(1, 16'h0000);
		end
		i_mvc_video_source.cycle(3, 16'h0000);
		repeat (40) @(negedge clk);
		check(48'(q.size()), 48'h0);
		check(48'(n_mw), 48'h0);
	endtask

	// frame-buffer memory: random ready, mask byte one cycle after a read is taken
	always @(negedge clk) begin
		logic r;
		r = !stall && ($urandom % 4 != 0);
		fb_rdata_valid = pend;
		fb_rdata = pend ? mem_byte(pa) : ~fb_rdata;
		pend = 1'b0;
		if (fb_valid && r && !fb_write) begin
			pa = fb_addr;
			pend = 1'b1;
		end
		if (fb_valid && r && chk) begin
			if (!fb_write || !men)
				cw = q.pop_front();
			// a set mask bit owes one write; the address wraps at the bus width
			if (!fb_write) begin
				check(48'(fb_addr), 48'(24'(mbase + (cw.addr >> 4))));
				n_mw = n_mw + int'(mbit(cw.addr));
			end else begin
				check({7'h0, men ? mbit(cw.addr) : 1'b1, fb_addr, fb_wdata},
					{8'h01, cw.addr, cw.pixel});
				n_mw = n_mw - int'(men);
			end
		end
		fb_ready = r;
	end

	// a hung handshake ends the run as a failure
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	initial begin
		void'($urandom(88592));
		repeat (4) @(negedge clk);
		rst = 1'b0;
		// reset values, including the unmapped 0x9b
		for (int a = 8'h96; a <= 8'h9f; a++) begin
			rd(8'(a));
			check(48'(v), 48'h0);
		end
		tmp = $urandom;
		cbase = {tmp[23:1], 1'b0};
		tmp = $urandom;
		mbase = tmp[23:0];
		ofs = {tmp[31:25], 1'b0};
		mkey = tmp[7:0] ^ 8'h5a;
		for (int i = 0; i < 3; i++) begin
			wr(8'(OFS_CAP_B0 + i), cbase[8*i +: 8]);
			wr(8'(OFS_MASK_B0 + i), mbase[8*i +: 8]);
		end
		wr(OFS_LINE, ofs);
		wr(8'h9b, 8'hff);
		for (int i = 0; i < 3; i++) begin
			rd(8'(OFS_CAP_B0 + i));
			check(48'(v), 48'(cbase[8*i +: 8]));
			rd(8'(OFS_MASK_B0 + i));
			check(48'(v), 48'(mbase[8*i +: 8]));
		end
		rd(OFS_LINE);
		check(48'(v), 48'(ofs));
		rd(8'h9b);
		check(48'(v), 48'h0);
		// with the clock enable low a register write must not land
		ce = 1'b0;
		wr(OFS_LINE, ~ofs);
		ce = 1'b1;
		rd(OFS_LINE);
		check(48'(v), 48'(ofs));
		// unmasked capture over two lines
		frame(2, 9);
		// masked capture; software owns the mask content
		men = 1'b1;
		wr(OFS_CTRL, 8'h01);
		rd(OFS_CTRL);
		check(48'(v), 48'h01);
		frame(3, 20);
		// overflow while memory stalls, field shown in status
		men = 1'b0;
		wr(OFS_CTRL, 8'h00);
		i_mvc_video_source.field_parity = 1'b1;
		chk = 1'b0;
		stall = 1'b1;
		frame(1, 5);
		rd(OFS_STATUS);
		check(48'(v), 48'h07);
		stall = 1'b0;
		repeat (60) @(negedge clk);
		wr(OFS_CTRL, 8'h02);
		rd(OFS_STATUS);
		check(48'(v), 48'h02);
		finish_test();
	end
endmodule // test_masked_video_capture_writer
